// *** iteiu_pkg.sv ***
// Shared constants and types for the interval timer / edge interrupt unit.
// Assumes one clock domain and an 8-bit processor bus.
package iteiu_pkg;
  localparam int ADDR_W         = 7;
  localparam int DATA_W         = 8;
  localparam int ABIT_SECT      = 2;
  localparam int ABIT_TIMER_IEN = 3;
  localparam int ABIT_TIMER_WR  = 4;
  localparam int ABIT_EDGE_POL  = 0;
  localparam int ABIT_EDGE_IEN  = 1;
  localparam int ABIT_FLAG_RD   = 0;
  localparam int TIMER_FLAG_BIT = 7;
  localparam int EDGE_FLAG_BIT  = 6;
  localparam logic [1:0] REG_PA_OUT = 2'h0;
  localparam logic [1:0] REG_PA_DIR = 2'h1;
  localparam logic [1:0] REG_PB_OUT = 2'h2;
  localparam logic [1:0] REG_PB_DIR = 2'h3;
  localparam logic [7:0] RST_PORT     = 8'h00;
  localparam logic [7:0] RST_COUNT    = 8'h00;
  localparam logic [7:0] COUNT_WRAP   = 8'hff;
  localparam logic [9:0] RST_PRESCALE = 10'h000;
  localparam logic [9:0] PRE_LAST_1    = 10'h000;
  localparam logic [9:0] PRE_LAST_8    = 10'h007;
  localparam logic [9:0] PRE_LAST_64   = 10'h03f;
  localparam logic [9:0] PRE_LAST_1024 = 10'h3ff;
  localparam logic       RST_EDGE_POL = 1'b0;
  localparam logic       RST_IEN      = 1'b0;
  localparam logic       RST_LEVEL    = 1'b0;

  typedef enum logic {TMR_COUNT = 1'b0, TMR_EXPIRED = 1'b1} iteiu_tstate_t;
  localparam iteiu_tstate_t RST_TSTATE = TMR_EXPIRED;

  function automatic logic [9:0] iteiu_pre_last(input logic [1:0] sel);
    case (sel)
      2'h0:    iteiu_pre_last = PRE_LAST_1;
      2'h1:    iteiu_pre_last = PRE_LAST_8;
      2'h2:    iteiu_pre_last = PRE_LAST_64;
      default: iteiu_pre_last = PRE_LAST_1024;
    endcase
  endfunction
endpackage

// *** iteiu_link_if.sv ***
// Carrier between the bus decoder and the timer and edge submodules.
// Strobes in here are one-cycle pulses in the clk domain.
`timescale 1ns/1ps
interface iteiu_link_if;
  logic       timer_load;
  logic [1:0] timer_sel;
  logic [7:0] timer_value;
  logic       timer_read;
  logic [7:0] timer_count;
  logic       timer_flag;
  logic       edge_level;
  logic       edge_rising;
  logic       edge_clear;
  logic       edge_flag;
  modport core_mp (output timer_load, timer_sel, timer_value, timer_read,
                   output edge_level, edge_rising, edge_clear,
                   input  timer_count, timer_flag, edge_flag);
  modport timer_mp (input timer_load, timer_sel, timer_value, timer_read,
                    output timer_count, timer_flag);
  modport edge_mp (input edge_level, edge_rising, edge_clear, output edge_flag);
endinterface

// *** iteiu_edge_detect.sv ***
// Edge detector on the top port A line with a sticky flag.
// Assumes the level is synchronous to clk.
`timescale 1ns/1ps
module iteiu_edge_detect
  import iteiu_pkg::*;
(
  input wire logic      clk,
  input wire logic      reset_n,
  iteiu_link_if.edge_mp lnk
);
  logic level_reg, level_next;
  logic flag_reg, flag_next;
  logic hit;

  assign lnk.edge_flag = flag_reg;

  always_comb begin
    level_next = lnk.edge_level;
    hit        = lnk.edge_rising ? (lnk.edge_level & ~level_reg)
                                 : (~lnk.edge_level & level_reg);
    flag_next  = flag_reg;
    if (lnk.edge_clear) flag_next = 1'b0;
    // Set wins over a clear in the same cycle
    if (hit) flag_next = 1'b1;
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      level_reg <= RST_LEVEL;
      flag_reg  <= 1'b0;
    end else begin
      level_reg <= level_next;
      flag_reg  <= flag_next;
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);
  property p_edge_fall;
    (!lnk.edge_rising && level_reg && !lnk.edge_level) |=> flag_reg;
  endproperty
  a_edge_fall: assert property (p_edge_fall) else $error("falling edge missed");
  property p_edge_rise;
    (lnk.edge_rising && !level_reg && lnk.edge_level) |=> flag_reg;
  endproperty
  a_edge_rise: assert property (p_edge_rise) else $error("rising edge missed");
  property p_edge_clear;
    (lnk.edge_clear && !hit) |=> !flag_reg;
  endproperty
  a_edge_clear: assert property (p_edge_clear) else $error("edge flag not cleared");
endmodule

// *** iteiu_interval_timer.sv ***
// Interval timer: prescaled 8-bit down-counter with timeout flag.
// Assumes load and read strobes are one-cycle pulses from the decoder.
`timescale 1ns/1ps
module iteiu_interval_timer
  import iteiu_pkg::*;
(
  input wire logic       clk,
  input wire logic       reset_n,
  iteiu_link_if.timer_mp lnk
);
  iteiu_tstate_t state_reg, state_next;
  logic [7:0]    count_reg, count_next;
  logic [9:0]    pre_reg, pre_next;
  logic [1:0]    sel_reg, sel_next;
  logic          flag_reg, flag_next;
  logic          timeout;

  assign lnk.timer_count = count_reg;
  assign lnk.timer_flag  = flag_reg;

  always_comb begin
    state_next = state_reg;
    count_next = count_reg;
    pre_next   = pre_reg;
    sel_next   = sel_reg;
    flag_next  = flag_reg;
    timeout    = 1'b0;
    if (lnk.timer_load) begin
      count_next = lnk.timer_value;
      sel_next   = lnk.timer_sel;
      pre_next   = RST_PRESCALE;
      state_next = TMR_COUNT;
      flag_next  = 1'b0;
    end else begin
      case (state_reg)
        TMR_EXPIRED: count_next = count_reg - 8'h01;
        default: begin
          // One clock past zero gives the (N x div) + 1 total
          if (count_reg == 8'h00) begin
            timeout    = 1'b1;
            count_next = COUNT_WRAP;
            state_next = TMR_EXPIRED;
          end else if (pre_reg == iteiu_pre_last(sel_reg)) begin
            count_next = count_reg - 8'h01;
            pre_next   = RST_PRESCALE;
          end else begin
            pre_next = pre_reg + 10'h001;
          end
        end
      endcase
      if (lnk.timer_read) flag_next = 1'b0;
      if (timeout) flag_next = 1'b1;
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      state_reg <= RST_TSTATE;
      count_reg <= RST_COUNT;
      pre_reg   <= RST_PRESCALE;
      sel_reg   <= 2'h0;
      flag_reg  <= 1'b0;
    end else begin
      state_reg <= state_next;
      count_reg <= count_next;
      pre_reg   <= pre_next;
      sel_reg   <= sel_next;
      flag_reg  <= flag_next;
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);
  sequence s_load8;
    lnk.timer_load && lnk.timer_sel == 2'h1 && lnk.timer_value != 8'h00;
  endsequence
  property p_div8;
    s_load8 ##1 (!lnk.timer_load) [*8] |=> count_reg == $past(lnk.timer_value, 9) - 8'h01;
  endproperty
  a_div8: assert property (p_div8) else $error("divide-by-8 interval wrong");
  property p_wrap;
    (state_reg == TMR_COUNT && count_reg == 8'h00 && !lnk.timer_load)
      |=> flag_reg && count_reg == COUNT_WRAP ##1 count_reg == 8'hfe;
  endproperty
  a_wrap: assert property (p_wrap) else $error("timeout wrap wrong");
  property p_clear;
    (state_reg == TMR_EXPIRED && (lnk.timer_read || lnk.timer_load)) |=> !flag_reg;
  endproperty
  a_clear: assert property (p_clear) else $error("timer flag not cleared");
  property p_read_at_timeout;
    (timeout && lnk.timer_read) |=> flag_reg;
  endproperty
  a_read_at_timeout: assert property (p_read_at_timeout) else $error("flag lost");
endmodule

// *** iteiu_core.sv ***
// Register section: select decode, port registers, timer and edge control.
// Assumes a synchronous 8-bit processor bus, one access per selected cycle.
`timescale 1ns/1ps
module iteiu_core
  import iteiu_pkg::*;
(
  input  wire logic              clk,
  input  wire logic              reset_n,
  input  wire logic              chip_enable_high,
  input  wire logic              chip_enable_low,
  input  wire logic              memory_select_n,
  input  wire logic              read_write,
  input  wire logic [ADDR_W-1:0] addr,
  input  wire logic [DATA_W-1:0] data_in,
  output      logic [DATA_W-1:0] data_out,
  output      logic              data_oe,
  output      logic              ram_select,
  input  wire logic [DATA_W-1:0] port_a_lines_in,
  output      logic [DATA_W-1:0] port_a_lines_out,
  output      logic [DATA_W-1:0] port_a_lines_oe,
  output      logic [DATA_W-1:0] port_b_lines_out,
  output      logic [DATA_W-1:0] port_b_lines_oe,
  output      logic              irq_n_out,
  output      logic              irq_n_oe
);
  iteiu_link_if lnk ();

  logic [7:0] pa_out_reg, pa_out_next;
  logic [7:0] pa_dir_reg, pa_dir_next;
  logic [7:0] pb_out_reg, pb_out_next;
  logic [7:0] pb_dir_reg, pb_dir_next;
  logic       timer_ien_reg, timer_ien_next;
  logic       edge_ien_reg, edge_ien_next;
  logic       edge_rising_reg, edge_rising_next;
  logic [7:0] dout_reg, dout_next;
  logic       doe_reg, doe_next;

  logic       chip_sel;
  logic       io_sel;
  logic       io_rd;
  logic       io_wr;
  logic       port_rd;
  logic       port_wr;
  logic       timer_wr;
  logic       timer_rd;
  logic       flag_rd;
  logic       edge_wr;
  logic       irq_active;
  logic [7:0] port_rdata;

  // Same index decode serves both reads and writes of the port registers
  function automatic logic is_port(input logic [ADDR_W-1:0] a, input logic [1:0] idx);
    is_port = !a[ABIT_SECT] && a[1:0] == idx;
  endfunction

  // Select and section decode
  assign chip_sel   = chip_enable_high & ~chip_enable_low;
  assign ram_select = chip_sel & ~memory_select_n;
  assign io_sel     = chip_sel & memory_select_n;
  assign io_rd      = io_sel & read_write;
  assign io_wr      = io_sel & ~read_write;
  assign port_rd    = io_rd & ~addr[ABIT_SECT];
  assign port_wr    = io_wr & ~addr[ABIT_SECT];
  assign timer_wr   = io_wr & addr[ABIT_SECT] & addr[ABIT_TIMER_WR];
  assign edge_wr    = io_wr & addr[ABIT_SECT] & ~addr[ABIT_TIMER_WR];
  assign timer_rd   = io_rd & addr[ABIT_SECT] & ~addr[ABIT_FLAG_RD];
  assign flag_rd    = io_rd & addr[ABIT_SECT] & addr[ABIT_FLAG_RD];

  // Strobes and levels to the submodules
  assign lnk.timer_load  = timer_wr;
  assign lnk.timer_sel   = addr[1:0];
  assign lnk.timer_value = data_in;
  assign lnk.timer_read  = timer_rd;
  assign lnk.edge_level  = port_a_lines_in[DATA_W-1];
  assign lnk.edge_rising = edge_rising_reg;
  assign lnk.edge_clear  = flag_rd;

  iteiu_interval_timer u_timer (
    .clk     (clk),
    .reset_n (reset_n),
    .lnk     (lnk.timer_mp)
  );

  iteiu_edge_detect u_edge (
    .clk     (clk),
    .reset_n (reset_n),
    .lnk     (lnk.edge_mp)
  );

  // Read mux for the port registers
  always_comb begin
    if (is_port(addr, REG_PA_OUT)) begin
      port_rdata = port_a_lines_in;
    end else if (is_port(addr, REG_PA_DIR)) begin
      port_rdata = pa_dir_reg;
    end else if (is_port(addr, REG_PB_OUT)) begin
      // Pins may be loaded down, so the register is the honest answer
      port_rdata = pb_out_reg;
    end else begin
      port_rdata = pb_dir_reg;
    end
  end

  // Register writes and control latches
  always_comb begin
    pa_out_next      = pa_out_reg;
    pa_dir_next      = pa_dir_reg;
    pb_out_next      = pb_out_reg;
    pb_dir_next      = pb_dir_reg;
    timer_ien_next   = timer_ien_reg;
    edge_ien_next    = edge_ien_reg;
    edge_rising_next = edge_rising_reg;
    if (port_wr) begin
      if (is_port(addr, REG_PA_OUT)) begin
        pa_out_next = data_in;
      end else if (is_port(addr, REG_PA_DIR)) begin
        pa_dir_next = data_in;
      end else if (is_port(addr, REG_PB_OUT)) begin
        pb_out_next = data_in;
      end else begin
        pb_dir_next = data_in;
      end
    end
    if (timer_wr || timer_rd) begin
      timer_ien_next = addr[ABIT_TIMER_IEN];
    end
    // Data lines are don't care for edge control
    if (edge_wr) begin
      edge_ien_next    = addr[ABIT_EDGE_IEN];
      edge_rising_next = addr[ABIT_EDGE_POL];
    end
  end

  // Read data is captured at the access edge and driven the next cycle
  always_comb begin
    dout_next = dout_reg;
    doe_next  = io_rd;
    if (port_rd) begin
      dout_next = port_rdata;
    end else if (timer_rd) begin
      dout_next = lnk.timer_count;
    end else if (flag_rd) begin
      dout_next = {lnk.timer_flag, lnk.edge_flag, 6'h00};
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      pa_out_reg      <= RST_PORT;
      pa_dir_reg      <= RST_PORT;
      pb_out_reg      <= RST_PORT;
      pb_dir_reg      <= RST_PORT;
      timer_ien_reg   <= RST_IEN;
      edge_ien_reg    <= RST_IEN;
      edge_rising_reg <= RST_EDGE_POL;
      dout_reg        <= RST_PORT;
      doe_reg         <= 1'b0;
    end else begin
      pa_out_reg      <= pa_out_next;
      pa_dir_reg      <= pa_dir_next;
      pb_out_reg      <= pb_out_next;
      pb_dir_reg      <= pb_dir_next;
      timer_ien_reg   <= timer_ien_next;
      edge_ien_reg    <= edge_ien_next;
      edge_rising_reg <= edge_rising_next;
      dout_reg        <= dout_next;
      doe_reg         <= doe_next;
    end
  end

  // Port drivers follow the direction bits per line
  assign port_a_lines_out = pa_out_reg;
  assign port_a_lines_oe  = pa_dir_reg;
  assign port_b_lines_out = pb_out_reg;
  assign port_b_lines_oe  = pb_dir_reg;

  assign data_out = dout_reg;
  assign data_oe  = doe_reg;

  // Open drain: only ever pulls low, the pull-up lives off chip
  assign irq_active = (lnk.timer_flag & timer_ien_reg)
                    | (lnk.edge_flag & edge_ien_reg);
  assign irq_n_out  = 1'b0;
  assign irq_n_oe   = irq_active;

  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);

  sequence s_pb_read;
    io_rd && is_port(addr, REG_PB_OUT);
  endsequence
  sequence s_pa_read;
    io_rd && is_port(addr, REG_PA_OUT);
  endsequence
  sequence s_dir_b_write;
    io_wr && is_port(addr, REG_PB_DIR);
  endsequence

  property p_pa_dir_wr;
    (io_wr && is_port(addr, REG_PA_DIR)) |=> pa_dir_reg == $past(data_in);
  endproperty
  a_pa_dir_wr: assert property (p_pa_dir_wr) else $error("port A direction write lost");
  property p_sect_split;
    (io_wr && !addr[ABIT_SECT]) |=> timer_ien_reg == $past(timer_ien_reg)
                                   && edge_ien_reg == $past(edge_ien_reg);
  endproperty
  a_sect_split: assert property (p_sect_split) else $error("port write hit timer section");
  property p_dir_drive;
    s_dir_b_write |=> port_b_lines_oe == $past(data_in) && port_b_lines_out == $past(pb_out_reg);
  endproperty
  a_dir_drive: assert property (p_dir_drive) else $error("port B drive mismatch");
  property p_pb_read;
    s_pb_read |=> data_oe && data_out == $past(pb_out_reg);
  endproperty
  a_pb_read: assert property (p_pb_read) else $error("port B read wrong");
  property p_pa_read;
    s_pa_read |=> data_oe && data_out == $past(port_a_lines_in);
  endproperty
  a_pa_read: assert property (p_pa_read) else $error("port A read wrong");
  property p_flag_read;
    flag_rd |=> data_out == {$past(lnk.timer_flag), $past(lnk.edge_flag), 6'h00};
  endproperty
  a_flag_read: assert property (p_flag_read) else $error("flag read wrong");
  property p_timer_read;
    timer_rd |=> data_oe && data_out == $past(lnk.timer_count);
  endproperty
  a_timer_read: assert property (p_timer_read) else $error("timer read wrong");
  property p_timer_load;
    timer_wr |=> lnk.timer_count == $past(data_in);
  endproperty
  a_timer_load: assert property (p_timer_load) else $error("timer load wrong");
  property p_edge_ctl;
    edge_wr |=> edge_ien_reg == $past(addr[ABIT_EDGE_IEN])
             && edge_rising_reg == $past(addr[ABIT_EDGE_POL]);
  endproperty
  a_edge_ctl: assert property (p_edge_ctl) else $error("edge control wrong");
  property p_timer_ien;
    (timer_wr || timer_rd) |=> timer_ien_reg == $past(addr[ABIT_TIMER_IEN]);
  endproperty
  a_timer_ien: assert property (p_timer_ien) else $error("timer enable not latched");
  property p_oe_cause;
    data_oe |-> $past(io_rd);
  endproperty
  a_oe_cause: assert property (p_oe_cause) else $error("data driven without read");
  property p_ram_quiet;
    ram_select |=> !data_oe;
  endproperty
  a_ram_quiet: assert property (p_ram_quiet) else $error("RAM access drove bus");
  property p_irq_edge;
    (lnk.edge_flag && edge_ien_reg) |-> irq_n_oe && !irq_n_out;
  endproperty
  a_irq_edge: assert property (p_irq_edge) else $error("edge interrupt not driven");
  property p_irq_timer;
    ($rose(lnk.timer_flag) && timer_ien_reg) |-> irq_n_oe;
  endproperty
  a_irq_timer: assert property (p_irq_timer) else $error("timer interrupt not driven");
  property p_reset_ports;
    $rose(reset_n) |-> pa_dir_reg == RST_PORT && pb_dir_reg == RST_PORT
                    && pa_out_reg == RST_PORT && pb_out_reg == RST_PORT;
  endproperty
  a_reset_ports: assert property (p_reset_ports) else $error("ports not cleared");
  property p_reset_edge;
    $rose(reset_n) |-> !edge_ien_reg && !edge_rising_reg && !irq_n_oe;
  endproperty
  a_reset_edge: assert property (p_reset_edge) else $error("edge control not reset");
  // Accesses outside the port block must leave all four port registers alone
  sequence s_ports_kept;
    pa_out_reg == $past(pa_out_reg) && pa_dir_reg == $past(pa_dir_reg)
      && pb_out_reg == $past(pb_out_reg) && pb_dir_reg == $past(pb_dir_reg);
  endsequence
  property p_pa_out_wr;
    (io_wr && is_port(addr, REG_PA_OUT)) |=> pa_out_reg == $past(data_in);
  endproperty
  a_pa_out_wr: assert property (p_pa_out_wr) else $error("port A output write lost");
  property p_pb_out_wr;
    (io_wr && is_port(addr, REG_PB_OUT)) |=> pb_out_reg == $past(data_in);
  endproperty
  a_pb_out_wr: assert property (p_pb_out_wr) else $error("port B output write lost");
  property p_pa_dir_rd;
    (io_rd && is_port(addr, REG_PA_DIR)) |=> data_oe && data_out == $past(pa_dir_reg);
  endproperty
  a_pa_dir_rd: assert property (p_pa_dir_rd) else $error("port A direction read wrong");
  property p_pb_dir_rd;
    (io_rd && is_port(addr, REG_PB_DIR)) |=> data_oe && data_out == $past(pb_dir_reg);
  endproperty
  a_pb_dir_rd: assert property (p_pb_dir_rd) else $error("port B direction read wrong");
  property p_idle_keep;
    !chip_sel |=> s_ports_kept;
  endproperty
  a_idle_keep: assert property (p_idle_keep) else $error("idle cycle changed a port");
  property p_ram_keep;
    ram_select |=> s_ports_kept;
  endproperty
  a_ram_keep: assert property (p_ram_keep) else $error("RAM access changed a port");
  property p_sect_keep;
    (io_wr && addr[ABIT_SECT]) |=> s_ports_kept;
  endproperty
  a_sect_keep: assert property (p_sect_keep) else $error("timer write changed a port");
  property p_write_quiet;
    io_wr |=> !data_oe;
  endproperty
  a_write_quiet: assert property (p_write_quiet) else $error("write drove the bus");
  property p_unsel_quiet;
    !chip_sel |=> !data_oe;
  endproperty
  a_unsel_quiet: assert property (p_unsel_quiet) else $error("idle cycle drove the bus");
  property p_timer_wr_edge;
    timer_wr |=> edge_ien_reg == $past(edge_ien_reg)
              && edge_rising_reg == $past(edge_rising_reg);
  endproperty
  a_timer_wr_edge: assert property (p_timer_wr_edge) else $error("edge control hit");
  property p_edge_wr_timer;
    edge_wr |=> timer_ien_reg == $past(timer_ien_reg);
  endproperty
  a_edge_wr_timer: assert property (p_edge_wr_timer) else $error("timer enable hit");
endmodule

// *** iteiu_cpu_model.sv ***
// Processor model that runs single-byte cycles on the chip's select bus.
// Assumes the bench calls acc from one process and shares clk with the core.
`timescale 1ns/1ps
module iteiu_cpu_model (
  input  wire logic       clk,
  input  wire logic [7:0] data_out,
  input  wire logic       data_oe,
  output      logic       chip_enable_high,
  output      logic       chip_enable_low,
  output      logic       memory_select_n,
  output      logic       read_write,
  output      logic [6:0] addr,
  output      logic [7:0] data_in
);
  int unsigned cyc = 0;
  int unsigned acc_cyc = 0;

  always @(posedge clk) begin
    cyc <= cyc + 1;
  end

  initial begin
    chip_enable_high = 1'b0;
    chip_enable_low = 1'b1;
    memory_select_n = 1'b1;
    read_write = 1'b1;
    addr = 7'h00;
    data_in = 8'h00;
  end

  // One selected edge per call; idle data is inverted so nothing stale looks valid
  task automatic acc(input logic rw, input logic [6:0] a, input logic [7:0] d,
                     input logic ram, output logic [7:0] q, output logic oe);
    @(posedge clk);
    #1;
    chip_enable_high = 1'b1;
    chip_enable_low = 1'b0;
    memory_select_n = ~ram;
    read_write = rw;
    addr = a;
    data_in = d;
    @(posedge clk);
    #1;
    acc_cyc = cyc;
    // Undriven bus floats, shown inverted so a missed drive cannot match
    q = data_oe ? data_out : ~data_out;
    oe = data_oe;
    chip_enable_high = 1'b0;
    chip_enable_low = 1'b1;
    data_in = ~d;
  endtask
endmodule

// *** tb_iteiu_core.sv ***
// Self-checking bench for the register section: ports, timer, flags, edge.
// Assumes the processor model drives every bus cycle of the core.
`timescale 1ns/1ps
module tb_iteiu_core;
  import iteiu_pkg::*;
  logic              clk, reset_n, chip_enable_high, chip_enable_low;
  logic              memory_select_n, read_write, data_oe, ram_select;
  logic              irq_n_out, irq_n_oe, oe;
  logic [6:0]        addr;
  logic [7:0]        data_in, data_out, port_a_lines_in, q, e;
  logic [7:0]        pao, paoe, pbo, pboe;
  int                fails, checked, d;
  int unsigned       t_cyc;
  int                ram_hits = 0;

  iteiu_core i_dut (.clk(clk), .reset_n(reset_n), .chip_enable_high(chip_enable_high),
    .chip_enable_low(chip_enable_low), .memory_select_n(memory_select_n),
    .read_write(read_write), .addr(addr), .data_in(data_in), .data_out(data_out),
    .data_oe(data_oe), .ram_select(ram_select), .port_a_lines_in(port_a_lines_in),
    .port_a_lines_out(pao), .port_a_lines_oe(paoe), .port_b_lines_out(pbo),
    .port_b_lines_oe(pboe), .irq_n_out(irq_n_out), .irq_n_oe(irq_n_oe));

  iteiu_cpu_model i_cpu (.clk(clk), .data_out(data_out), .data_oe(data_oe),
    .chip_enable_high(chip_enable_high), .chip_enable_low(chip_enable_low),
    .memory_select_n(memory_select_n), .read_write(read_write), .addr(addr),
    .data_in(data_in));

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  always @(posedge clk) begin
    if (ram_select === 1'b1) ram_hits <= ram_hits + 1;
  end

  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    checked++;
    if (got !== exp) begin
      fails++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic wr(input logic [6:0] a, input logic [7:0] dv);
    i_cpu.acc(1'b0, a, dv, 1'b0, q, oe);
  endtask

  task automatic rd(input logic [6:0] a);
    i_cpu.acc(1'b1, a, 8'h00, 1'b0, q, oe);
  endtask

  task automatic wrap_up;
    $display("checks %0d mismatches %0d", checked, fails);
    if (fails == 0 && checked > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  initial begin
    #100_000;
    fails++;
    wrap_up;
  end

  initial begin
    fails = 0;
    checked = 0;
    reset_n = 1'b0;
    port_a_lines_in = 8'h00;
    repeat (12) @(posedge clk);
    chk("ports in reset", 16'h0000, 16'(pao | paoe | pbo | pboe));
    chk("drives in reset", 16'h0000, {14'h0000, data_oe, irq_n_oe});
    chk("irq pin value", 16'h0000, 16'(irq_n_out));
    #1 reset_n = 1'b1;
    rd(7'h05);
    chk("flags after reset", 16'h0000, 16'(q));
    $display("test reset done");

    wr(7'h00, 8'h5a);
    wr(7'h01, 8'hf0);
    wr(7'h02, 8'ha5);
    wr(7'h03, 8'h0f);
    chk("port lines", 16'h5af0, {pao, paoe});
    chk("port b lines", 16'ha50f, {pbo, pboe});
    port_a_lines_in = 8'h3c;
    rd(7'h00);
    chk("port a read", 16'h003c, 16'(q));
    rd(7'h01);
    chk("port a dir read", 16'h00f0, 16'(q));
    rd(7'h02);
    chk("port b read", 16'h00a5, 16'(q));
    rd(7'h03);
    chk("port b dir read", 16'h000f, 16'(q));
    i_cpu.acc(1'b0, 7'h00, 8'h11, 1'b1, q, oe);
    chk("ram write ignored", 16'h005a, 16'(pao));
    i_cpu.acc(1'b1, 7'h00, 8'h00, 1'b1, q, oe);
    chk("ram read drive", 16'h0000, 16'(oe));
    chk("ram selects", 16'h0002, 16'(ram_hits));
    $display("test ports done");

    for (int s = 0; s < 4; s++) begin
      d = (s == 0) ? 1 : (s == 1) ? 8 : (s == 2) ? 64 : 1024;
      wr(7'h1c | 7'(s), 8'h02);
      t_cyc = i_cpu.acc_cyc;
      if (s != 0) begin
        rd(7'h1c);
        chk("remaining", 16'h0002, 16'(q));
      end
      for (int k = 0; k < 2100 && irq_n_oe !== 1'b1; k++) begin
        @(posedge clk);
        #1;
      end
      chk("timeout delay", 16'(2 * d + 1), 16'(i_cpu.cyc - t_cyc));
      t_cyc = i_cpu.cyc;
      rd(7'h05);
      chk("timer flag", 16'h0080, 16'(q));
      rd(7'h04);
      e = 8'hff - 8'(i_cpu.acc_cyc - 1 - t_cyc);
      chk("count after timeout", 16'(e), 16'(q));
      chk("irq after read", 16'h0000, 16'(irq_n_oe));
      rd(7'h05);
      chk("timer flag cleared", 16'h0000, 16'(q));
      $display("test timer prescale %0d done", d);
    end

    wr(7'h1c, 8'h01);
    rd(7'h14);
    chk("count at timeout", 16'h0000, 16'(q));
    chk("irq with enable off", 16'h0000, 16'(irq_n_oe));
    rd(7'h05);
    chk("flag kept at timeout", 16'h0080, 16'(q));
    rd(7'h04);
    rd(7'h05);
    chk("flag cleared later", 16'h0000, 16'(q));
    $display("test read at timeout done");

    wr(7'h07, 8'h00);
    port_a_lines_in = 8'hbc;
    repeat (3) @(posedge clk);
    #1;
    chk("edge irq", 16'h0001, 16'(irq_n_oe));
    rd(7'h05);
    chk("edge flag", 16'h0040, 16'(q));
    rd(7'h05);
    chk("edge flag cleared", 16'h0000, {q, 7'h00, irq_n_oe});
    port_a_lines_in = 8'h3c;
    repeat (3) @(posedge clk);
    rd(7'h05);
    chk("inactive edge", 16'h0000, 16'(q));
    wr(7'h04, 8'hff);
    port_a_lines_in = 8'hbc;
    repeat (3) @(posedge clk);
    #1 port_a_lines_in = 8'h3c;
    repeat (3) @(posedge clk);
    #1;
    chk("edge irq disabled", 16'h0000, 16'(irq_n_oe));
    rd(7'h05);
    chk("falling edge flag", 16'h0040, 16'(q));
    $display("test edge done");
    wrap_up;
  end
endmodule
